// ---- hdl/jdp_pkg.sv ----
/*
  types of the jtag / debug pin block: tap state enumeration and word types.
  assumes jdp_regs.svh is on the include path.
*/
`include "jdp_regs.svh"

package jdp_pkg;

  typedef enum logic [3:0] {
    TAP_RESET,
    TAP_IDLE,
    TAP_SEL_DR,
    TAP_CAP_DR,
    TAP_SHIFT_DR,
    TAP_EXIT1_DR,
    TAP_PAUSE_DR,
    TAP_EXIT2_DR,
    TAP_UPD_DR,
    TAP_SEL_IR,
    TAP_CAP_IR,
    TAP_SHIFT_IR,
    TAP_EXIT1_IR,
    TAP_PAUSE_IR,
    TAP_EXIT2_IR,
    TAP_UPD_IR
  } jdp_tap_e;

  typedef logic [`JDP_IR_BITS-1:0]    jdp_ir_t;
  typedef logic [`JDP_BSR_BITS-1:0]   jdp_bsr_t;
  typedef logic [`JDP_FRAME_BITS-1:0] jdp_frame_t;

endpackage

// ---- hdl/jdp_regs.svh ----
/*
  constants for the jtag / debug pin block: instruction codes, shift lengths,
  frame length of the debug serial port and the synchroniser bit positions.
  assumes it is included by bare name from the package and the top module.
*/
// Behaviour
// - strap 0 gives tms/tdi/tdo/trst, strap 1 gives breakpoint/serial in/out/clock
// - debug mode: breakpoint pin low raises a hardware breakpoint
// - debug mode: commands arrive serially on the serial input pin
// - debug mode: responses leave serially on the serial output pin
// - trst low asynchronously resets tap, loads bypass, jtag stays inert
// - trst, tms and tdi read as one when undriven
// - tms high for five tck rises reaches test-logic-reset
// - sixteen-state tap moves or holds on tck rise per tms
// - tdi shifts into selected register on tck rise
// - selected register shifts out on tdo at tck fall
// - tdo floats whenever no test data is shifted out
// - tap runs on tck and keeps state with tck stopped
// - float strap floats outputs at once, no clock involved
// - float strap never overrides jtag; trst floats tdo instead
// - reset with float strap gives master reset, refresh included
// - reset without float strap is normal reset, refresh kept running
`ifndef JDP_REGS_SVH
`define JDP_REGS_SVH

`define JDP_IR_BITS      4
`define JDP_IR_BYPASS    4'hF
`define JDP_IR_EXTEST    4'h0
`define JDP_IR_SAMPLE    4'h1
`define JDP_IR_CAPTURE   4'h1
`define JDP_BSR_BITS     8
`define JDP_FRAME_BITS   17
`define JDP_FRAME_CNT_W  5
`define JDP_FRAME_LAST   5'h10

`define JDP_SYNC_BITS    6
`define JDP_SY_DEBUG_BREAKPOINT_N      0
`define JDP_SY_DEBUG_SERIAL_CLOCK     1
`define JDP_SY_DSI       2
`define JDP_SY_RSTN      3
`define JDP_SY_FLOATN    4
`define JDP_SY_STRAP     5

`endif

// ---- hdl/jdp_sync3.sv ----
/*
  three-flop pin synchroniser, one lane per bit; a lane's output follows
  only when the second and third flops agree.
  assumes clk is the processor clock and nrst its synchronous reset.
*/
`timescale 1ns/1ps
`include "jdp_regs.svh"

module jdp_sync3 (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic [`JDP_SYNC_BITS-1:0] pin,
  input  wire logic [`JDP_SYNC_BITS-1:0] init,
  output logic      [`JDP_SYNC_BITS-1:0] level
);

  genvar i;
  generate
    for (i = 0; i < `JDP_SYNC_BITS; i++) begin : g_lane
      logic s1;
      logic s2;
      logic s3;
      // s1 feeds s2 only, so metastability never reaches a gate
      always_ff @(posedge clk) begin
        if (!nrst) begin
          s1 <= init[i];
          s2 <= init[i];
          s3 <= init[i];
        end else begin
          s1 <= pin[i];
          s2 <= s1;
          s3 <= s2;
        end
      end
      always_ff @(posedge clk) begin
        if (!nrst) begin
          level[i] <= init[i];
        end else if (s2 == s3) begin
          level[i] <= s3;
        end
      end
    end
  endgenerate

endmodule

// ---- hdl/jdp_top.sv ----
/*
  shared test / debug pins: jtag tap on tck, debug serial port and reset
  mode decode on clk, pin multiplexing by the mode strap.
  assumes the mode strap is static while reset_in_n is high and that tck and
  clk are unrelated; the tap reset net is the trst pin gated by the strap.
*/
`timescale 1ns/1ps
`include "jdp_regs.svh"

module jdp_top (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       tck,
  input  wire logic                       test_mode_strap,
  input  wire logic                       reset_in_n,
  input  wire logic                       float_outputs_n,
  input  wire logic                       trst_debug_serial_clock_in,
  input  wire logic                       trst_debug_serial_clock_driven,
  input  wire logic                       tms_debug_breakpoint_n_in,
  input  wire logic                       tms_debug_breakpoint_n_driven,
  input  wire logic                       tdi_dsi_in,
  input  wire logic                       tdi_dsi_driven,
  output logic                            tdo_dso_out,
  output logic                            tdo_dso_oe,
  input  wire logic [`JDP_BSR_BITS-1:0]   bsr_capture,
  output logic      [`JDP_BSR_BITS-1:0]   bsr_update,
  input  wire logic [`JDP_FRAME_BITS-1:0] resp_word,
  input  wire logic                       resp_load,
  output logic      [`JDP_FRAME_BITS-1:0] cmd_word,
  output logic                            cmd_valid,
  output logic                            hw_breakpoint,
  output logic                            jtag_inert,
  output logic                            master_reset,
  output logic                            normal_reset,
  output logic                            refresh_reset
);

  // undriven pins read high, like the pad pull-ups
  logic trst_pin;
  logic tms_pin;
  logic tdi_pin;
  assign trst_pin = trst_debug_serial_clock_driven ? trst_debug_serial_clock_in : 1'b1;
  assign tms_pin  = tms_debug_breakpoint_n_driven ? tms_debug_breakpoint_n_in : 1'b1;
  assign tdi_pin  = tdi_dsi_driven ? tdi_dsi_in : 1'b1;

  // tck domain: tap controller
  // in debug mode the tap is held in reset so the shared pins are free
  logic trst_int_n;
  logic tms_eff;
  assign trst_int_n = !test_mode_strap && trst_pin;
  assign tms_eff    = test_mode_strap | tms_pin;

  jdp_pkg::jdp_tap_e   tap_state;
  jdp_pkg::jdp_tap_e   next_tap_state;
  jdp_pkg::jdp_ir_t    ir;
  jdp_pkg::jdp_ir_t    ir_sh;
  jdp_pkg::jdp_bsr_t   bsr_sh;
  logic                bypass_q;
  logic                tdo_q;
  logic                tdo_en;
  logic                tap_rst_flag;
  logic                sel_bsr;

  assign sel_bsr = (ir == `JDP_IR_EXTEST) || (ir == `JDP_IR_SAMPLE);

  always_comb begin
    next_tap_state = tap_state;
    unique case (tap_state)
      jdp_pkg::TAP_RESET:    next_tap_state = tms_eff ? jdp_pkg::TAP_RESET  : jdp_pkg::TAP_IDLE;
      jdp_pkg::TAP_IDLE:     next_tap_state = tms_eff ? jdp_pkg::TAP_SEL_DR : jdp_pkg::TAP_IDLE;
      jdp_pkg::TAP_SEL_DR:   next_tap_state = tms_eff ? jdp_pkg::TAP_SEL_IR : jdp_pkg::TAP_CAP_DR;
      jdp_pkg::TAP_CAP_DR:   next_tap_state = tms_eff ? jdp_pkg::TAP_EXIT1_DR
                                                      : jdp_pkg::TAP_SHIFT_DR;
      jdp_pkg::TAP_SHIFT_DR: next_tap_state = tms_eff ? jdp_pkg::TAP_EXIT1_DR
                                                      : jdp_pkg::TAP_SHIFT_DR;
      jdp_pkg::TAP_EXIT1_DR: next_tap_state = tms_eff ? jdp_pkg::TAP_UPD_DR
                                                      : jdp_pkg::TAP_PAUSE_DR;
      jdp_pkg::TAP_PAUSE_DR: next_tap_state = tms_eff ? jdp_pkg::TAP_EXIT2_DR
                                                      : jdp_pkg::TAP_PAUSE_DR;
      jdp_pkg::TAP_EXIT2_DR: next_tap_state = tms_eff ? jdp_pkg::TAP_UPD_DR
                                                      : jdp_pkg::TAP_SHIFT_DR;
      jdp_pkg::TAP_UPD_DR:   next_tap_state = tms_eff ? jdp_pkg::TAP_SEL_DR : jdp_pkg::TAP_IDLE;
      jdp_pkg::TAP_SEL_IR:   next_tap_state = tms_eff ? jdp_pkg::TAP_RESET  : jdp_pkg::TAP_CAP_IR;
      jdp_pkg::TAP_CAP_IR:   next_tap_state = tms_eff ? jdp_pkg::TAP_EXIT1_IR
                                                      : jdp_pkg::TAP_SHIFT_IR;
      jdp_pkg::TAP_SHIFT_IR: next_tap_state = tms_eff ? jdp_pkg::TAP_EXIT1_IR
                                                      : jdp_pkg::TAP_SHIFT_IR;
      jdp_pkg::TAP_EXIT1_IR: next_tap_state = tms_eff ? jdp_pkg::TAP_UPD_IR
                                                      : jdp_pkg::TAP_PAUSE_IR;
      jdp_pkg::TAP_PAUSE_IR: next_tap_state = tms_eff ? jdp_pkg::TAP_EXIT2_IR
                                                      : jdp_pkg::TAP_PAUSE_IR;
      jdp_pkg::TAP_EXIT2_IR: next_tap_state = tms_eff ? jdp_pkg::TAP_UPD_IR
                                                      : jdp_pkg::TAP_SHIFT_IR;
      jdp_pkg::TAP_UPD_IR:   next_tap_state = tms_eff ? jdp_pkg::TAP_SEL_DR : jdp_pkg::TAP_IDLE;
    endcase
  end

  // purely edge driven: a stopped tck leaves every flop as it is
  always_ff @(posedge tck or negedge trst_int_n) begin
    if (!trst_int_n) begin
      tap_state <= jdp_pkg::TAP_RESET;
    end else begin
      tap_state <= next_tap_state;
    end
  end

  always_ff @(posedge tck or negedge trst_int_n) begin
    if (!trst_int_n) begin
      ir    <= `JDP_IR_BYPASS;
      ir_sh <= `JDP_IR_BYPASS;
    end else begin
      unique case (tap_state)
        jdp_pkg::TAP_RESET:    ir    <= `JDP_IR_BYPASS;
        jdp_pkg::TAP_CAP_IR:   ir_sh <= `JDP_IR_CAPTURE;
        jdp_pkg::TAP_SHIFT_IR: ir_sh <= {tdi_pin, ir_sh[`JDP_IR_BITS-1:1]};
        jdp_pkg::TAP_UPD_IR:   ir    <= ir_sh;
        default: ;
      endcase
    end
  end

  always_ff @(posedge tck or negedge trst_int_n) begin
    if (!trst_int_n) begin
      bypass_q   <= 1'b0;
      bsr_sh     <= '0;
      bsr_update <= '0;
    end else begin
      if (tap_state == jdp_pkg::TAP_CAP_DR) begin
        bypass_q <= 1'b0;
        if (sel_bsr) begin
          bsr_sh <= bsr_capture;
        end
      end else if (tap_state == jdp_pkg::TAP_SHIFT_DR) begin
        if (sel_bsr) begin
          bsr_sh <= {tdi_pin, bsr_sh[`JDP_BSR_BITS-1:1]};
        end else begin
          bypass_q <= tdi_pin;
        end
      end else if (tap_state == jdp_pkg::TAP_UPD_DR && ir == `JDP_IR_EXTEST) begin
        bsr_update <= bsr_sh;
      end
    end
  end

  // tdo changes on the falling edge so the far end samples mid-bit
  always_ff @(negedge tck or negedge trst_int_n) begin
    if (!trst_int_n) begin
      tdo_q  <= 1'b0;
      tdo_en <= 1'b0;
    end else begin
      tdo_en <= (tap_state == jdp_pkg::TAP_SHIFT_DR) ||
                (tap_state == jdp_pkg::TAP_SHIFT_IR);
      if (tap_state == jdp_pkg::TAP_SHIFT_IR) begin
        tdo_q <= ir_sh[0];
      end else if (sel_bsr) begin
        tdo_q <= bsr_sh[0];
      end else begin
        tdo_q <= bypass_q;
      end
    end
  end

  always_ff @(posedge tck or negedge trst_int_n) begin
    if (!trst_int_n) begin
      tap_rst_flag <= 1'b1;
    end else begin
      tap_rst_flag <= (next_tap_state == jdp_pkg::TAP_RESET);
    end
  end

  // clk domain: pin synchronisers
  logic [`JDP_SYNC_BITS-1:0] sync_pin;
  logic [`JDP_SYNC_BITS-1:0] sync_init;
  logic [`JDP_SYNC_BITS-1:0] sync_lvl;
  assign sync_pin  = {test_mode_strap, float_outputs_n, reset_in_n,
                      tdi_pin, trst_pin, tms_pin};
  assign sync_init = {1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

  jdp_sync3 u_sync (
    .clk   (clk),
    .nrst  (nrst),
    .pin   (sync_pin),
    .init  (sync_init),
    .level (sync_lvl)
  );

  logic strap_f;
  logic debug_breakpoint_n_f;
  logic debug_serial_clock_f;
  logic dsi_f;
  logic rstn_f;
  logic floatn_f;
  assign strap_f  = sync_lvl[`JDP_SY_STRAP];
  assign debug_breakpoint_n_f   = sync_lvl[`JDP_SY_DEBUG_BREAKPOINT_N];
  assign debug_serial_clock_f  = sync_lvl[`JDP_SY_DEBUG_SERIAL_CLOCK];
  assign dsi_f    = sync_lvl[`JDP_SY_DSI];
  assign rstn_f   = sync_lvl[`JDP_SY_RSTN];
  assign floatn_f = sync_lvl[`JDP_SY_FLOATN];

  // tap reset level crosses into clk through three flops; debug mode holds
  // the tap in reset, so the flag alone covers both cases
  logic inert_s1;
  logic inert_s2;
  logic inert_s3;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      inert_s1   <= 1'b1;
      inert_s2   <= 1'b1;
      inert_s3   <= 1'b1;
      jtag_inert <= 1'b1;
    end else begin
      inert_s1 <= tap_rst_flag;
      inert_s2 <= inert_s1;
      inert_s3 <= inert_s2;
      if (inert_s2 == inert_s3) begin
        jtag_inert <= inert_s3;
      end
    end
  end

  // breakpoint: one pulse per falling edge of the pin in debug mode
  logic debug_breakpoint_n_d;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      debug_breakpoint_n_d        <= 1'b1;
      hw_breakpoint <= 1'b0;
    end else begin
      debug_breakpoint_n_d        <= debug_breakpoint_n_f;
      hw_breakpoint <= strap_f && debug_breakpoint_n_d && !debug_breakpoint_n_f;
    end
  end

  // debug serial port; needs debug_serial_clock at most a quarter of clk (each level held two clk cycles) or edges get lost
  logic                             debug_serial_clock_d;
  logic                             ds_rise;
  logic                             ds_fall;
  logic [`JDP_FRAME_CNT_W-1:0]      ds_cnt;
  logic [`JDP_FRAME_BITS-2:0]       ds_in_sh;
  jdp_pkg::jdp_frame_t              ds_out_sh;
  logic                             dso_q;
  assign ds_rise = strap_f && !debug_serial_clock_d && debug_serial_clock_f;
  assign ds_fall = strap_f && debug_serial_clock_d && !debug_serial_clock_f;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      debug_serial_clock_d <= 1'b1;
    end else begin
      debug_serial_clock_d <= debug_serial_clock_f;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ds_cnt    <= '0;
      ds_in_sh  <= '0;
      cmd_word  <= '0;
      cmd_valid <= 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      if (!strap_f) begin
        ds_cnt <= '0;
      end else if (ds_rise) begin
        if (ds_cnt == `JDP_FRAME_LAST) begin
          cmd_word  <= {ds_in_sh, dsi_f};
          cmd_valid <= 1'b1;
          ds_cnt    <= '0;
        end else begin
          ds_in_sh <= {ds_in_sh[`JDP_FRAME_BITS-3:0], dsi_f};
          ds_cnt   <= ds_cnt + 1'b1;
        end
      end
    end
  end

  // a load wins over a shift in the same cycle so no response is dropped
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ds_out_sh <= '0;
      dso_q     <= 1'b0;
    end else begin
      if (resp_load) begin
        ds_out_sh <= resp_word;
      end else if (ds_fall) begin
        ds_out_sh <= {ds_out_sh[`JDP_FRAME_BITS-2:0], 1'b0};
      end
      dso_q <= ds_out_sh[`JDP_FRAME_BITS-1];
    end
  end

  // reset mode decode
  always_ff @(posedge clk) begin
    if (!nrst) begin
      master_reset  <= 1'b0;
      normal_reset  <= 1'b0;
      refresh_reset <= 1'b0;
    end else begin
      master_reset  <= !rstn_f && !floatn_f;
      refresh_reset <= !rstn_f && !floatn_f;
      normal_reset  <= !rstn_f && floatn_f;
    end
  end

  // shared output pin; the static strap picks the source, float acts without
  // a clock but only on the debug output so jtag keeps its own control
  assign tdo_dso_out = test_mode_strap ? dso_q : tdo_q;
  assign tdo_dso_oe  = test_mode_strap ? float_outputs_n : tdo_en;

  // checks
  sequence s_tms_high5;
    tms_eff [*5];
  endsequence

  sequence s_reset_float;
    !rstn_f && !floatn_f;
  endsequence

  a_tap_five_ones: assert property (@(posedge tck) disable iff (!trst_int_n)
    s_tms_high5 |=> tap_state == jdp_pkg::TAP_RESET)
    else $error("tap not in reset after five tms ones");

  a_tap_idle_hold: assert property (@(posedge tck) disable iff (!trst_int_n)
    tap_state == jdp_pkg::TAP_IDLE && !tms_eff |=> tap_state == jdp_pkg::TAP_IDLE)
    else $error("tap left idle with tms low");

  a_ir_bypass_load: assert property (@(posedge tck) disable iff (!trst_int_n)
    tap_state == jdp_pkg::TAP_RESET |=> ir == `JDP_IR_BYPASS)
    else $error("instruction not bypass after tap reset");

  a_bypass_shift: assert property (@(posedge tck) disable iff (!trst_int_n)
    tap_state == jdp_pkg::TAP_SHIFT_DR && !sel_bsr |=> bypass_q == $past(tdi_pin))
    else $error("bypass bit did not take tdi");

  a_tdo_float: assert property (@(negedge tck) disable iff (!trst_int_n)
    tap_state != jdp_pkg::TAP_SHIFT_DR && tap_state != jdp_pkg::TAP_SHIFT_IR |=> !tdo_en)
    else $error("tdo driven outside a shift state");

  a_tdo_ir_data: assert property (@(negedge tck) disable iff (!trst_int_n)
    tap_state == jdp_pkg::TAP_SHIFT_IR |=> tdo_q == $past(ir_sh[0]))
    else $error("tdo not carrying instruction bit");

  a_master_reset: assert property (@(posedge clk) disable iff (!nrst)
    s_reset_float ##1 s_reset_float |-> master_reset && refresh_reset && !normal_reset)
    else $error("master reset not decoded");

  a_normal_reset: assert property (@(posedge clk) disable iff (!nrst)
    !rstn_f && floatn_f |=> normal_reset && !refresh_reset && !master_reset)
    else $error("normal reset touched refresh");

  a_debug_breakpoint_n_pulse: assert property (@(posedge clk) disable iff (!nrst)
    strap_f && $fell(debug_breakpoint_n_f) |=> hw_breakpoint ##1 !hw_breakpoint)
    else $error("breakpoint pulse wrong");

  a_cmd_frame: assert property (@(posedge clk) disable iff (!nrst)
    ds_rise && ds_cnt == `JDP_FRAME_LAST |=> cmd_valid && cmd_word[0] == $past(dsi_f))
    else $error("command frame not delivered");

  a_float_debug: assert property (@(posedge clk) disable iff (!nrst)
    test_mode_strap && !float_outputs_n |-> !tdo_dso_oe)
    else $error("debug output driven while floated");

  a_jtag_keeps_oe: assert property (@(posedge clk) disable iff (!nrst)
    !test_mode_strap |-> tdo_dso_oe == tdo_en)
    else $error("float strap overrode tdo");

endmodule

// ---- tb/jdp_probe.sv ----
/*
  behavioural jtag tester / debug probe on the shared test pins.
  assumes it is driven by task calls from the bench; tck stands low between calls.
*/
`timescale 1ns/1ps

module jdp_probe (
  output logic      tck,
  output logic      trst_debug_serial_clock_in,
  output logic      trst_debug_serial_clock_driven,
  output logic      tms_debug_breakpoint_n_in,
  output logic      tms_debug_breakpoint_n_driven,
  output logic      tdi_dsi_in,
  output logic      tdi_dsi_driven,
  input  wire logic tdo_dso_out,
  input  wire logic tdo_dso_oe
);
  localparam realtime HALF     = 7.5;
  localparam realtime DS_PHASE = 32.0;

  initial begin
    tck = 1'b0;
    trst_debug_serial_clock_in = 1'b1;
    trst_debug_serial_clock_driven = 1'b1;
    tms_debug_breakpoint_n_in = 1'b1;
    tms_debug_breakpoint_n_driven = 1'b1;
    tdi_dsi_in = 1'b1;
    tdi_dsi_driven = 1'b1;
  end

  // trst pulse; released only with tms held high
  task automatic tap_reset_async();
    tms_debug_breakpoint_n_in = 1'b1;
    trst_debug_serial_clock_in = 1'b0;
    #40;
    trst_debug_serial_clock_in = 1'b1;
    #20;
  endtask

  // one tck period; tdo is taken just before the rising edge, as a tester would
  task automatic tck_cycle(input logic tms, input logic tdi, output logic tdo, output logic oe);
    tms_debug_breakpoint_n_in = tms;
    tdi_dsi_in = tdi;
    #HALF;
    tdo = tdo_dso_out;
    oe = tdo_dso_oe;
    tck = 1'b1;
    #HALF;
    tck = 1'b0;
  endtask

  // tms released: the pin value toggles so only the pull-up can give a one
  task automatic tck_float_tms(input int n);
    tms_debug_breakpoint_n_driven = 1'b0;
    repeat (n) begin
      tms_debug_breakpoint_n_in = ~tms_debug_breakpoint_n_in;
      #HALF tck = 1'b1;
      #HALF tck = 1'b0;
    end
    tms_debug_breakpoint_n_driven = 1'b1;
    tms_debug_breakpoint_n_in = 1'b1;
  endtask

  // serial clock parks low between frames
  task automatic debug_serial_clock_idle();
    trst_debug_serial_clock_in = 1'b0;
  endtask

  // 64 ns serial period, far below half the processor clock rate
  task automatic ds_bit(input logic d, output logic so);
    tdi_dsi_in = d;
    #DS_PHASE;
    so = tdo_dso_out;
    trst_debug_serial_clock_in = 1'b1;
    #DS_PHASE;
    trst_debug_serial_clock_in = 1'b0;
  endtask

  task automatic debug_breakpoint_n_pulse();
    tms_debug_breakpoint_n_in = 1'b0;
    #40;
    tms_debug_breakpoint_n_in = 1'b1;
  endtask
endmodule

// ---- tb/jdp_tb_top.sv ----
/*
  self-checking bench for the shared test / debug pin block.
  assumes jdp_top with its include file and the probe model are compiled first.
*/
`timescale 1ns/1ps
`include "jdp_regs.svh"

module jdp_tb_top;
  logic                       clk, nrst, tck, test_mode_strap, reset_in_n, float_outputs_n;
  logic                       trst_debug_serial_clock_in, trst_debug_serial_clock_driven, tms_debug_breakpoint_n_in, tms_debug_breakpoint_n_driven;
  logic                       tdi_dsi_in, tdi_dsi_driven, tdo_dso_out, tdo_dso_oe;
  logic [`JDP_BSR_BITS-1:0]   bsr_capture, bsr_update;
  logic [`JDP_FRAME_BITS-1:0] resp_word, cmd_word;
  logic                       resp_load, cmd_valid, hw_breakpoint, jtag_inert;
  logic                       master_reset, normal_reset, refresh_reset;
  int                         failures, num_checks;

  jdp_top i_jdp_top (.clk(clk), .nrst(nrst), .tck(tck), .test_mode_strap(test_mode_strap),
    .reset_in_n(reset_in_n), .float_outputs_n(float_outputs_n),
    .trst_debug_serial_clock_in(trst_debug_serial_clock_in), .trst_debug_serial_clock_driven(trst_debug_serial_clock_driven),
    .tms_debug_breakpoint_n_in(tms_debug_breakpoint_n_in), .tms_debug_breakpoint_n_driven(tms_debug_breakpoint_n_driven),
    .tdi_dsi_in(tdi_dsi_in), .tdi_dsi_driven(tdi_dsi_driven),
    .tdo_dso_out(tdo_dso_out), .tdo_dso_oe(tdo_dso_oe), .bsr_capture(bsr_capture),
    .bsr_update(bsr_update), .resp_word(resp_word), .resp_load(resp_load),
    .cmd_word(cmd_word), .cmd_valid(cmd_valid), .hw_breakpoint(hw_breakpoint),
    .jtag_inert(jtag_inert), .master_reset(master_reset), .normal_reset(normal_reset),
    .refresh_reset(refresh_reset));

  jdp_probe i_jdp_probe (.tck(tck), .trst_debug_serial_clock_in(trst_debug_serial_clock_in),
    .trst_debug_serial_clock_driven(trst_debug_serial_clock_driven), .tms_debug_breakpoint_n_in(tms_debug_breakpoint_n_in),
    .tms_debug_breakpoint_n_driven(tms_debug_breakpoint_n_driven), .tdi_dsi_in(tdi_dsi_in),
    .tdi_dsi_driven(tdi_dsi_driven), .tdo_dso_out(tdo_dso_out), .tdo_dso_oe(tdo_dso_oe));

  always #2 clk = ~clk;

  task automatic check(input logic [16:0] seen, input logic [16:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t ns %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask

  // ends on a falling edge so outputs of the last rising edge have landed
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic test_resets();
    settle(8);
    check(17'({master_reset, refresh_reset, normal_reset}), 17'h6, "master reset");
    @(posedge clk) float_outputs_n <= 1'b1;
    settle(8);
    check(17'({master_reset, refresh_reset, normal_reset}), 17'h1, "normal reset");
    @(posedge clk) reset_in_n <= 1'b1;
    settle(8);
    check(17'({master_reset, refresh_reset, normal_reset}), 17'h0, "run");
    $display("test resets done");
  endtask

  task automatic test_bypass();
    logic       tdo, oe;
    logic [7:0] pat, got;
    pat = 8'hA5;
    i_jdp_probe.tap_reset_async();
    settle(8);
    check(17'(jtag_inert), 17'h1, "inert after trst");
    check(17'(tdo_dso_oe), 17'h0, "tdo floats");
    i_jdp_probe.tck_cycle(1'b0, 1'b1, tdo, oe);
    i_jdp_probe.tck_cycle(1'b1, 1'b1, tdo, oe);
    i_jdp_probe.tck_cycle(1'b0, 1'b1, tdo, oe);
    i_jdp_probe.tck_cycle(1'b0, 1'b1, tdo, oe);
    // float strap low in jtag mode must leave tdo driving
    @(posedge clk) float_outputs_n <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      i_jdp_probe.tck_cycle(i == 7, pat[i], tdo, oe);
      got[i] = tdo;
      check(17'(oe), 17'h1, "tdo drives in shift");
    end
    check(17'(got), 17'({pat[6:0], 1'b0}), "bypass data");
    i_jdp_probe.tck_cycle(1'b1, 1'b1, tdo, oe);
    check(17'(oe), 17'h0, "tdo floats after shift");
    i_jdp_probe.tck_cycle(1'b0, 1'b1, tdo, oe);
    @(posedge clk) float_outputs_n <= 1'b1;
    settle(8);
    check(17'(jtag_inert), 17'h0, "tap active");
    $display("test bypass done");
  endtask

  task automatic test_extest();
    logic       tdo, oe;
    logic [7:0] pat, got;
    logic [3:0] ir;
    pat = 8'h96;
    ir = `JDP_IR_EXTEST;
    got = '0;
    @(posedge clk) bsr_capture <= 8'h3C;
    i_jdp_probe.tck_cycle(1'b1, 1'b1, tdo, oe);
    i_jdp_probe.tck_cycle(1'b1, 1'b1, tdo, oe);
    i_jdp_probe.tck_cycle(1'b0, 1'b1, tdo, oe);
    i_jdp_probe.tck_cycle(1'b0, 1'b1, tdo, oe);
    for (int i = 0; i < `JDP_IR_BITS; i++) begin
      i_jdp_probe.tck_cycle(i == `JDP_IR_BITS - 1, ir[i], tdo, oe);
      got[i] = tdo;
    end
    check(17'(got[3:0]), 17'(`JDP_IR_CAPTURE), "ir capture");
    i_jdp_probe.tck_cycle(1'b1, 1'b1, tdo, oe);
    i_jdp_probe.tck_cycle(1'b0, 1'b1, tdo, oe);
    i_jdp_probe.tck_cycle(1'b1, 1'b1, tdo, oe);
    i_jdp_probe.tck_cycle(1'b0, 1'b1, tdo, oe);
    i_jdp_probe.tck_cycle(1'b0, 1'b1, tdo, oe);
    for (int i = 0; i < 8; i++) begin
      i_jdp_probe.tck_cycle(i == 7, pat[i], tdo, oe);
      got[i] = tdo;
    end
    check(17'(got), 17'h3C, "boundary capture");
    i_jdp_probe.tck_cycle(1'b1, 1'b1, tdo, oe);
    i_jdp_probe.tck_cycle(1'b0, 1'b1, tdo, oe);
    check(17'(bsr_update), 17'(pat), "boundary update");
    // tck stopped for a long while
    settle(200);
    check(17'(bsr_update), 17'(pat), "state kept");
    i_jdp_probe.tck_float_tms(5);
    settle(8);
    check(17'(jtag_inert), 17'h1, "five tms ones reset");
    $display("test extest done");
  endtask

  task automatic test_debug();
    logic [16:0] cmd, rsp, seen_cmd;
    logic        so;
    int          n, m;
    cmd = 17'h0F0F1;
    n = 0;
    m = 0;
    seen_cmd = '0;
    i_jdp_probe.debug_serial_clock_idle();
    @(posedge clk) reset_in_n <= 1'b0;
    @(posedge clk) test_mode_strap <= 1'b1;
    settle(8);
    @(posedge clk) reset_in_n <= 1'b1;
    settle(8);
    check(17'(jtag_inert), 17'h1, "debug mode inert");
    check(17'(tdo_dso_oe), 17'h1, "serial out drives");
    fork
      i_jdp_probe.debug_breakpoint_n_pulse();
      repeat (40) begin
        @(negedge clk);
        if (hw_breakpoint === 1'b1) n++;
      end
    join
    check(17'(n), 17'h1, "one breakpoint");
    @(posedge clk) begin
      resp_word <= 17'h1A5C3;
      resp_load <= 1'b1;
    end
    @(posedge clk) resp_load <= 1'b0;
    settle(4);
    fork
      for (int i = 16; i >= 0; i--) begin
        i_jdp_probe.ds_bit(cmd[i], so);
        rsp[i] = so;
      end
      repeat (320) begin
        @(negedge clk);
        if (cmd_valid === 1'b1) begin
          m++;
          seen_cmd = cmd_word;
        end
      end
    join
    check(rsp, 17'h1A5C3, "response bits");
    check(17'(m), 17'h1, "one command");
    check(seen_cmd, cmd, "command word");
    @(posedge clk) float_outputs_n <= 1'b0;
    @(negedge clk);
    check(17'(tdo_dso_oe), 17'h0, "float strap");
    @(posedge clk) float_outputs_n <= 1'b1;
    $display("test debug done");
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    test_mode_strap = 1'b0;
    reset_in_n = 1'b0;
    float_outputs_n = 1'b0;
    bsr_capture = '0;
    resp_word = '0;
    resp_load = 1'b0;
    failures = 0;
    num_checks = 0;
    // power-on trst pulse so the tck-side flops start known
    #1;
    i_jdp_probe.tap_reset_async();
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    test_resets();
    test_bypass();
    test_extest();
    test_debug();
    complete_run();
  end
endmodule
